// File: hw/edmam_regs.svh
// sizes, field positions, reset values and timing counts of the address mapper
//
// How it works
// - mode 00 keeps every move on chip
// - internal mode folds addresses into populated RAM
// - internal 8-bit: page high, indirect register low
// - internal 16-bit uses the data pointer, folded into RAM
// - split modes: below RAM size on chip
// - no bank select 8-bit: upper lines float
// - no bank select 16-bit drives all lines
// - bank select 8-bit: page high, register low
// - mode 11 sends every move off chip
// - external-only 8-bit ignores page, upper float
// - external-only 16-bit drives data pointer throughout
// - config 110 selects non-multiplexed bank-select bus
`ifndef EDMAM_REGS_SVH
`define EDMAM_REGS_SVH

`define EDMAM_CFG_MODE_LSB   2
`define EDMAM_CFG_MODE_MSB   3
`define EDMAM_CFG_NONMUX_BIT 4
`define EDMAM_WRAP_BYTES     8192
`define EDMAM_RAM_BYTES      8192
`define EDMAM_STROBE_CYCLES  3
`define EDMAM_RDATA_RESET    8'h00
`define EDMAM_STROBE_IDLE    1'b1

`endif

// File: hw/edmam_pkg.sv
// types of the external data memory address mapper
package edmam_pkg;

    typedef enum logic [1:0] {
        EDMAM_MODE_INTERNAL = 2'b00,
        EDMAM_MODE_SPLIT_NB = 2'b01,
        EDMAM_MODE_SPLIT_BS = 2'b10,
        EDMAM_MODE_EXTERNAL = 2'b11
    } edmam_mode_t;

    typedef enum logic [1:0] {
        EDMAM_ST_IDLE    = 2'b00,
        EDMAM_ST_ONCHIP  = 2'b01,
        EDMAM_ST_OFFCHIP = 2'b10
    } edmam_state_t;

    typedef struct packed {
        edmam_state_t state;
        logic [7:0]   cnt;
        logic         busy;
        logic         done;
        logic         onchip_req;
        logic         onchip_we;
        logic [15:0]  onchip_addr;
        logic [7:0]   wdata;
        logic [15:0]  ext_addr;
        logic         hi_oe;
        logic         lo_oe;
        logic         data_oe;
        logic         rd_n;
        logic         wr_n;
        logic         nonmux;
        logic [7:0]   rdata;
    } edmam_regs_t;

endpackage : edmam_pkg

// File: hw/edmam_route_if.sv
// route decision passed from the decoder to the access sequencer
`timescale 1ns/1ps
interface edmam_route_if;
    logic [15:0] eff_addr;
    logic [15:0] onchip_addr;
    logic        to_offchip;
    logic        hi_drive;

    modport route (output eff_addr, output onchip_addr, output to_offchip, output hi_drive);
    modport ctrl  (input eff_addr, input onchip_addr, input to_offchip, input hi_drive);
endinterface : edmam_route_if

// File: hw/edmam_route.sv
// effective address and on-chip / off-chip decode
`timescale 1ns/1ps
`include "edmam_regs.svh"
module edmam_route #(
    parameter int RAM_BYTES = `EDMAM_RAM_BYTES
) (
    input  wire logic [7:0]  memory_interface_config_i,
    input  wire logic        move_wide_i,
    input  wire logic        move_sel_one_i,
    input  wire logic [7:0]  external_data_ram_page_select_i,
    input  wire logic [7:0]  indirect_register_zero_i,
    input  wire logic [7:0]  indirect_register_one_i,
    input  wire logic [15:0] data_pointer_i,
    edmam_route_if.route     rt
);
    localparam logic [15:0] RAM_MASK = 16'(RAM_BYTES - 1);
    localparam logic [16:0] RAM_SIZE = 17'(RAM_BYTES);

    edmam_pkg::edmam_mode_t mode;
    logic [7:0]             rn;
    logic [15:0]            eff;

    function automatic logic ram_hit(input logic [15:0] a);
        ram_hit = {1'b0, a} < RAM_SIZE;
    endfunction : ram_hit

    assign mode = edmam_pkg::edmam_mode_t'(memory_interface_config_i[`EDMAM_CFG_MODE_MSB:`EDMAM_CFG_MODE_LSB]);
    assign rn   = move_sel_one_i ? indirect_register_one_i : indirect_register_zero_i;

    always_comb begin
        if (move_wide_i) begin
            eff = data_pointer_i;
        end else if (mode == edmam_pkg::EDMAM_MODE_EXTERNAL) begin
            eff = {8'h00, rn};
        end else begin
            eff = {external_data_ram_page_select_i, rn};
        end
    end

    always_comb begin
        case (mode)
            edmam_pkg::EDMAM_MODE_INTERNAL: rt.to_offchip = 1'b0;
            edmam_pkg::EDMAM_MODE_SPLIT_NB: rt.to_offchip = !ram_hit(eff);
            edmam_pkg::EDMAM_MODE_SPLIT_BS: rt.to_offchip = !ram_hit(eff);
            edmam_pkg::EDMAM_MODE_EXTERNAL: rt.to_offchip = 1'b1;
            default:                        rt.to_offchip = 1'b0;
        endcase
    end

    assign rt.eff_addr    = eff;
    assign rt.onchip_addr = eff & RAM_MASK;
    assign rt.hi_drive    = move_wide_i || (mode == edmam_pkg::EDMAM_MODE_SPLIT_BS);
endmodule : edmam_route

// File: hw/edmam_top.sv
// external data move address mapper: routes each move on chip or onto the bus
`timescale 1ns/1ps
`include "edmam_regs.svh"
module edmam_top #(
    parameter int RAM_BYTES     = `EDMAM_RAM_BYTES,
    parameter int STROBE_CYCLES = `EDMAM_STROBE_CYCLES
) (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_i,
    input  wire logic        move_req_i,
    input  wire logic        move_wide_i,
    input  wire logic        move_write_i,
    input  wire logic        move_sel_one_i,
    input  wire logic [7:0]  move_wdata_i,
    input  wire logic [7:0]  memory_interface_config_i,
    input  wire logic [7:0]  external_data_ram_page_select_i,
    input  wire logic [7:0]  indirect_register_zero_i,
    input  wire logic [7:0]  indirect_register_one_i,
    input  wire logic [15:0] data_pointer_i,
    input  wire logic [7:0]  onchip_rdata_i,
    input  wire logic [7:0]  ext_data_i,
    output logic             busy_o,
    output logic             done_o,
    output logic [7:0]       rdata_o,
    output logic             onchip_req_o,
    output logic             onchip_we_o,
    output logic [15:0]      onchip_addr_o,
    output logic [7:0]       onchip_wdata_o,
    output logic [15:0]      ext_addr_o,
    output logic             ext_addr_hi_oe_o,
    output logic             ext_addr_lo_oe_o,
    output logic [7:0]       ext_data_o,
    output logic             ext_data_oe_o,
    output logic             ext_rd_n_o,
    output logic             ext_wr_n_o,
    output logic             ext_nonmux_o
);
    localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYCLES - 1);

    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    generate
        if (RAM_BYTES < 256 || RAM_BYTES > `EDMAM_WRAP_BYTES || (RAM_BYTES & (RAM_BYTES - 1)) != 0) begin : g_bad_ram
            $error("RAM_BYTES must be a power of two from 256 to the wrap period");
        end
        if (STROBE_CYCLES < 1 || STROBE_CYCLES > 255) begin : g_bad_strobe
            $error("STROBE_CYCLES must lie in 1..255");
        end
    endgenerate

    edmam_route_if rt ();

    edmam_route #(
        .RAM_BYTES (RAM_BYTES)
    ) u_route (
        .memory_interface_config_i (memory_interface_config_i),
        .move_wide_i               (move_wide_i),
        .move_sel_one_i            (move_sel_one_i),
        .external_data_ram_page_select_i        (external_data_ram_page_select_i),
        .indirect_register_zero_i  (indirect_register_zero_i),
        .indirect_register_one_i   (indirect_register_one_i),
        .data_pointer_i            (data_pointer_i),
        .rt                        (rt)
    );

    edmam_pkg::edmam_regs_t st_reg;
    edmam_pkg::edmam_regs_t st_next;

    always_comb begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        case (st_reg.state)
            edmam_pkg::EDMAM_ST_IDLE: begin
                if (move_req_i) begin
                    st_next.busy  = 1'b1;
                    st_next.wdata = move_wdata_i;
                    if (!rt.to_offchip) begin
                        // on-chip move: bus pins stay idle
                        st_next.state       = edmam_pkg::EDMAM_ST_ONCHIP;
                        st_next.onchip_req  = 1'b1;
                        st_next.onchip_we   = move_write_i;
                        st_next.onchip_addr = rt.onchip_addr;
                    end else begin
                        st_next.state    = edmam_pkg::EDMAM_ST_OFFCHIP;
                        st_next.cnt      = STROBE_LAST;
                        st_next.ext_addr = rt.eff_addr;
                        st_next.hi_oe    = rt.hi_drive;
                        st_next.lo_oe    = 1'b1;
                        st_next.data_oe  = move_write_i;
                        st_next.rd_n     = move_write_i;
                        st_next.wr_n     = !move_write_i;
                        st_next.nonmux   = memory_interface_config_i[`EDMAM_CFG_NONMUX_BIT];
                    end
                end
            end
            edmam_pkg::EDMAM_ST_ONCHIP: begin
                st_next.onchip_req = 1'b0;
                st_next.onchip_we  = 1'b0;
                st_next.rdata      = onchip_rdata_i;
                st_next.done       = 1'b1;
                st_next.busy       = 1'b0;
                st_next.state      = edmam_pkg::EDMAM_ST_IDLE;
            end
            edmam_pkg::EDMAM_ST_OFFCHIP: begin
                if (st_reg.cnt == 8'h00) begin
                    if (!st_reg.rd_n) begin
                        st_next.rdata = ext_data_i;
                    end
                    st_next.hi_oe   = 1'b0;
                    st_next.lo_oe   = 1'b0;
                    st_next.data_oe = 1'b0;
                    st_next.rd_n    = `EDMAM_STROBE_IDLE;
                    st_next.wr_n    = `EDMAM_STROBE_IDLE;
                    st_next.done    = 1'b1;
                    st_next.busy    = 1'b0;
                    st_next.state   = edmam_pkg::EDMAM_ST_IDLE;
                end else begin
                    st_next.cnt = st_reg.cnt - 8'h01;
                end
            end
            default: begin
                st_next.state = edmam_pkg::EDMAM_ST_IDLE;
                st_next.busy  = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            st_reg       <= '0;
            st_reg.rd_n  <= `EDMAM_STROBE_IDLE;
            st_reg.wr_n  <= `EDMAM_STROBE_IDLE;
            st_reg.rdata <= `EDMAM_RDATA_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    assign busy_o           = st_reg.busy;
    assign done_o           = st_reg.done;
    assign rdata_o          = st_reg.rdata;
    assign onchip_req_o     = st_reg.onchip_req;
    assign onchip_we_o      = st_reg.onchip_we;
    assign onchip_addr_o    = st_reg.onchip_addr;
    assign onchip_wdata_o   = st_reg.wdata;
    assign ext_addr_o       = st_reg.ext_addr;
    assign ext_addr_hi_oe_o = st_reg.hi_oe;
    assign ext_addr_lo_oe_o = st_reg.lo_oe;
    assign ext_data_o       = st_reg.wdata;
    assign ext_data_oe_o    = st_reg.data_oe;
    assign ext_rd_n_o       = st_reg.rd_n;
    assign ext_wr_n_o       = st_reg.wr_n;
    assign ext_nonmux_o     = st_reg.nonmux;

    // helper terms for the checks below
    logic [1:0]  chk_mode;
    logic [7:0]  chk_rn;
    logic        chk_start;
    logic [15:0] chk_page_addr;
    logic [16:0] chk_ram_size;
    logic        chk_dp_low;
    logic        chk_pg_low;

    assign chk_mode      = memory_interface_config_i[`EDMAM_CFG_MODE_MSB:`EDMAM_CFG_MODE_LSB];
    assign chk_rn        = move_sel_one_i ? indirect_register_one_i : indirect_register_zero_i;
    assign chk_start     = move_req_i && !busy_o;
    assign chk_page_addr = {external_data_ram_page_select_i, chk_rn};
    assign chk_ram_size  = 17'(RAM_BYTES);
    assign chk_dp_low    = {1'b0, data_pointer_i} < chk_ram_size;
    assign chk_pg_low    = {1'b0, chk_page_addr} < chk_ram_size;

    a_internal_stays_on: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h0 |=> onchip_req_o ##1 (done_o && ext_rd_n_o && ext_wr_n_o))
        else $error("internal mode move reached the bus");

    a_internal_fold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h0 && move_wide_i
        |=> onchip_addr_o == ($past(data_pointer_i) & 16'(RAM_BYTES - 1)))
        else $error("internal address not folded into RAM");

    a_internal_page: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h0 && !move_wide_i
        |=> onchip_addr_o == ($past(chk_page_addr) & 16'(RAM_BYTES - 1)))
        else $error("internal 8-bit address not page and register");

    a_internal_wide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h0 && move_wide_i && {1'b0, data_pointer_i} < chk_ram_size
        |=> onchip_addr_o == $past(data_pointer_i))
        else $error("internal 16-bit address not data pointer");

    a_split_route_off: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && (chk_mode == 2'h1 || chk_mode == 2'h2) && move_wide_i && {1'b0, data_pointer_i} >= chk_ram_size
        |=> !onchip_req_o && ext_addr_lo_oe_o && (ext_rd_n_o != ext_wr_n_o))
        else $error("split mode high address stayed on chip");

    a_split_route_on: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && (chk_mode == 2'h1 || chk_mode == 2'h2) && move_wide_i && {1'b0, data_pointer_i} < chk_ram_size
        |=> onchip_req_o && !ext_addr_lo_oe_o)
        else $error("split mode low address went off chip");

    a_nobank_float: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h1 && !move_wide_i && {1'b0, chk_page_addr} >= chk_ram_size
        |=> !ext_addr_hi_oe_o && ext_addr_lo_oe_o && ext_addr_o[7:0] == $past(chk_rn))
        else $error("no bank select 8-bit drove upper lines");

    a_nobank_wide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h1 && move_wide_i && {1'b0, data_pointer_i} >= chk_ram_size
        |=> (ext_addr_hi_oe_o && ext_addr_lo_oe_o && ext_addr_o == $past(data_pointer_i, 1)) ##1
            (ext_addr_hi_oe_o && ext_addr_o == $past(data_pointer_i, 2)))
        else $error("no bank select 16-bit address not held");

    a_bank_full: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h2 && !move_wide_i && {1'b0, chk_page_addr} >= chk_ram_size
        |=> ext_addr_hi_oe_o && ext_addr_lo_oe_o && ext_addr_o == $past(chk_page_addr))
        else $error("bank select 8-bit address wrong");

    a_extern_all: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h3 |=> !onchip_req_o && ext_addr_lo_oe_o)
        else $error("external-only move reached on-chip RAM");

    a_extern_byte: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && chk_mode == 2'h3 && !move_wide_i
        |=> !ext_addr_hi_oe_o && ext_addr_o == {8'h00, $past(chk_rn)})
        else $error("external-only 8-bit address wrong");

    a_extern_wide: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (!ext_rd_n_o || !ext_wr_n_o) && ext_addr_lo_oe_o && $past(busy_o) |-> $stable(ext_addr_o) && $stable(ext_addr_hi_oe_o))
        else $error("off-chip address changed during a strobe");

    a_nonmux_bank: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        chk_start && memory_interface_config_i[4:2] == 3'h6 && !move_wide_i && {1'b0, chk_page_addr} >= chk_ram_size
        |=> ext_nonmux_o && ext_addr_hi_oe_o)
        else $error("config 110 did not select non-multiplexed bank select");

    a_onchip_quiet: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        onchip_req_o |-> ext_rd_n_o && ext_wr_n_o && !ext_data_oe_o && !ext_addr_lo_oe_o && !ext_addr_hi_oe_o)
        else $error("bus active during on-chip move");

    a_strobe_length: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        $fell(ext_rd_n_o) |-> !ext_rd_n_o [*3] ##1 (ext_rd_n_o && done_o))
        else $error("read strobe length wrong");

    a_internal_byte_on: assert property (
        chk_start && chk_mode == 2'h0 && !move_wide_i
        |=> onchip_req_o && !ext_addr_lo_oe_o)
        else $error("internal 8-bit move left the chip");

    a_internal_write: assert property (
        chk_start && chk_mode == 2'h0
        |=> onchip_we_o == $past(move_write_i)
            && onchip_wdata_o == $past(move_wdata_i))
        else $error("internal move lost direction or data");

    a_split_byte_on: assert property (
        chk_start && chk_mode inside {2'h1, 2'h2} && !move_wide_i && chk_pg_low
        |=> onchip_req_o
            && onchip_addr_o == $past(chk_page_addr))
        else $error("split low page address left the chip");

    a_split_byte_off: assert property (
        chk_start && chk_mode inside {2'h1, 2'h2} && !move_wide_i && !chk_pg_low
        |=> !onchip_req_o && ext_addr_lo_oe_o)
        else $error("split high page address stayed on chip");

    a_strobe_low_lines: assert property (
        !ext_rd_n_o || !ext_wr_n_o
        |-> ext_addr_lo_oe_o)
        else $error("lower lines undriven during a strobe");

    a_nobank_wide_hold: assert property (
        chk_start && chk_mode == 2'h1 && move_wide_i && !chk_dp_low
        |=> (ext_addr_hi_oe_o && ext_addr_lo_oe_o) [*3]
            ##1 (done_o && !ext_addr_hi_oe_o))
        else $error("no bank 16-bit lines not held");

    a_bank_byte_hold: assert property (
        chk_start && chk_mode == 2'h2 && !move_wide_i && !chk_pg_low
        |=> (ext_addr_hi_oe_o && ext_addr_lo_oe_o) [*3]
            ##1 (done_o && !ext_addr_lo_oe_o))
        else $error("bank 8-bit lines not held");

    a_extern_low_off: assert property (
        chk_start && chk_mode == 2'h3 && move_wide_i && chk_dp_low
        |=> !onchip_req_o
            && ext_addr_o == $past(data_pointer_i))
        else $error("external-only low address stayed on chip");

    a_extern_byte_hold: assert property (
        chk_start && chk_mode == 2'h3 && !move_wide_i
        |=> !ext_addr_hi_oe_o [*3] ##1 done_o)
        else $error("external-only 8-bit drove upper lines");

    a_nonmux_copy: assert property (
        chk_start && chk_mode == 2'h3
        |=> ext_nonmux_o == $past(memory_interface_config_i[`EDMAM_CFG_NONMUX_BIT]))
        else $error("bus kind not taken from config");

    a_data_oe_write: assert property (
        !ext_rd_n_o || !ext_wr_n_o
        |-> ext_data_oe_o == !ext_wr_n_o)
        else $error("data drive does not match strobe");

    a_onchip_done: assert property (
        onchip_req_o
        |=> done_o && !onchip_req_o && !busy_o)
        else $error("on-chip move did not finish");

    a_done_idle: assert property (
        done_o
        |-> ext_rd_n_o && ext_wr_n_o && !ext_data_oe_o
            && !ext_addr_lo_oe_o && !ext_addr_hi_oe_o && !busy_o)
        else $error("bus not idle at move end");

endmodule : edmam_top

// File: verif/edmam_ext_mem.sv
// behavioural model of the external parallel memory on the off-chip bus
`timescale 1ns/1ps
module edmam_ext_mem (
    input  wire logic        clk_sys_i,
    input  wire logic [15:0] addr_i,
    input  wire logic        addr_hi_oe_i,
    input  wire logic        addr_lo_oe_i,
    input  wire logic [7:0]  port_latch_i,
    input  wire logic [7:0]  data_i,
    input  wire logic        data_oe_i,
    input  wire logic        rd_n_i,
    input  wire logic        wr_n_i,
    output logic      [7:0]  data_o
);
    logic [7:0]  mem [0:65535];
    logic [15:0] pin_addr;
    logic [7:0]  last;

    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[15:8] ^ i[7:0] ^ 8'h5C;
        end
        last = 8'h00;
    end

    // undriven upper lines show the port latch value
    assign pin_addr[15:8] = addr_hi_oe_i ? addr_i[15:8] : port_latch_i;
    assign pin_addr[7:0]  = addr_lo_oe_i ? addr_i[7:0] : ~addr_i[7:0];
    // released data bus shows the inverse of the last value
    assign data_o = !rd_n_i ? mem[pin_addr] : ~last;

    always @(posedge clk_sys_i) begin
        if (!rd_n_i) begin
            last <= mem[pin_addr];
        end
        if (!wr_n_i && data_oe_i) begin
            mem[pin_addr] <= data_i;
        end
    end
endmodule : edmam_ext_mem

// File: verif/external_data_memory_address_mapper_tb.sv
// self-checking bench of the external data move address mapper
`timescale 1ns/1ps
module external_data_memory_address_mapper_tb;
    localparam logic [7:0] LATCH  = 8'hA5;
    localparam int         STROBE = 3;
    logic        clk_sys_i, reset_i, move_req_i, move_wide_i, move_write_i, move_sel_one_i;
    logic [7:0]  move_wdata_i, memory_interface_config_i, external_data_ram_page_select_i;
    logic [7:0]  indirect_register_zero_i, indirect_register_one_i, onchip_rdata_i, ext_data_i;
    logic [15:0] data_pointer_i;
    logic        busy_o, done_o, onchip_req_o, onchip_we_o, ext_addr_hi_oe_o, ext_addr_lo_oe_o;
    logic        ext_data_oe_o, ext_rd_n_o, ext_wr_n_o, ext_nonmux_o;
    logic [7:0]  rdata_o, onchip_wdata_o, ext_data_o, rd_got;
    logic [15:0] onchip_addr_o, ext_addr_o, on_addr, ex_addr;
    logic        saw_on, saw_oe, stable, hi, lo, nmux;
    logic [7:0]  ram [0:8191];
    int          n_strb, error_cnt, n_compared;

    edmam_top #(.RAM_BYTES(8192), .STROBE_CYCLES(STROBE)) uut (
        .clk_sys_i, .reset_i, .move_req_i, .move_wide_i, .move_write_i, .move_sel_one_i, .move_wdata_i,
        .memory_interface_config_i, .external_data_ram_page_select_i, .indirect_register_zero_i, .indirect_register_one_i,
        .data_pointer_i, .onchip_rdata_i, .ext_data_i, .busy_o, .done_o, .rdata_o, .onchip_req_o, .onchip_we_o,
        .onchip_addr_o, .onchip_wdata_o, .ext_addr_o, .ext_addr_hi_oe_o, .ext_addr_lo_oe_o, .ext_data_o,
        .ext_data_oe_o, .ext_rd_n_o, .ext_wr_n_o, .ext_nonmux_o);

    edmam_ext_mem mem_model (
        .clk_sys_i, .addr_i(ext_addr_o), .addr_hi_oe_i(ext_addr_hi_oe_o), .addr_lo_oe_i(ext_addr_lo_oe_o),
        .port_latch_i(LATCH), .data_i(ext_data_o), .data_oe_i(ext_data_oe_o), .rd_n_i(ext_rd_n_o),
        .wr_n_i(ext_wr_n_o), .data_o(ext_data_i));

    // on-chip RAM answers combinationally while the request stands
    assign onchip_rdata_i = ram[onchip_addr_o[12:0]];
    always @(posedge clk_sys_i) begin
        if (onchip_req_o && onchip_we_o) begin
            ram[onchip_addr_o[12:0]] <= onchip_wdata_o;
        end
    end

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[15:8] ^ a[7:0] ^ 8'h5C;
    endfunction : pat

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up

    // one move; records routing and bus activity until done
    task automatic move(input logic [7:0] cfg, input logic wide, input logic wr, input logic sel,
                        input logic [7:0] pg, input logic [7:0] rn, input logic [15:0] dp, input logic [7:0] wd);
        saw_on = 0;
        saw_oe = 0;
        n_strb = 0;
        stable = 1;
        memory_interface_config_i <= cfg;
        move_wide_i <= wide;
        move_write_i <= wr;
        move_sel_one_i <= sel;
        external_data_ram_page_select_i <= pg;
        indirect_register_zero_i <= sel ? ~rn : rn;
        indirect_register_one_i <= sel ? rn : ~rn;
        data_pointer_i <= dp;
        move_wdata_i <= wd;
        move_req_i <= 1'b1;
        @(posedge clk_sys_i);
        move_req_i <= 1'b0;
        for (int n = 0; n < 40; n++) begin
            @(negedge clk_sys_i);
            if (onchip_req_o === 1'b1) begin
                saw_on = 1;
                on_addr = onchip_addr_o;
            end
            if (ext_addr_lo_oe_o !== 1'b0 || ext_addr_hi_oe_o !== 1'b0 || ext_data_oe_o !== 1'b0) saw_oe = 1;
            if (ext_rd_n_o === 1'b0 || ext_wr_n_o === 1'b0) begin
                if (n_strb > 0 && ext_addr_o !== ex_addr) stable = 0;
                ex_addr = ext_addr_o;
                hi = ext_addr_hi_oe_o;
                lo = ext_addr_lo_oe_o;
                nmux = ext_nonmux_o;
                n_strb++;
            end
            if (done_o === 1'b1) break;
        end
        check("move done", done_o, 16'h0001);
        rd_got = rdata_o;
        @(posedge clk_sys_i);
    endtask : move

    task automatic s_internal();
        move(8'h00, 1'b1, 1'b1, 1'b0, 8'h00, 8'h00, 16'h2010, 8'h5A);
        check("internal on chip", saw_on, 16'h0001);
        check("internal wrap", on_addr, 16'h0010);
        check("internal bus idle", {saw_oe, 16'(n_strb)}, 16'h0000);
        move(8'h00, 1'b0, 1'b0, 1'b1, 8'h21, 8'h10, 16'hFFFF, 8'h00);
        check("internal 8-bit addr", on_addr, 16'h0110);
        move(8'h00, 1'b1, 1'b0, 1'b0, 8'hFF, 8'hFF, 16'h0010, 8'h00);
        check("internal 16-bit addr", on_addr, 16'h0010);
        check("internal read back", rd_got, 16'h005A);
        check("internal no strobe", {saw_oe, 16'(n_strb)}, 16'h0000);
    endtask : s_internal

    task automatic s_split();
        move(8'h04, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h1FFF, 8'h00);
        check("split below size", {saw_on, 16'(n_strb)}, 16'h0000 | 17'h10000);
        move(8'h04, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h2000, 8'h00);
        check("split at size off", saw_on, 16'h0000);
        check("split 16-bit addr", ex_addr, 16'h2000);
        check("split 16-bit oe", {hi, lo}, 16'h0003);
        check("split 16-bit data", rd_got, pat(16'h2000));
        move(8'h04, 1'b0, 1'b0, 1'b1, 8'h30, 8'h77, 16'h0000, 8'h00);
        check("split 8-bit oe", {hi, lo}, 16'h0001);
        check("split 8-bit low", ex_addr[7:0], 16'h0077);
        check("split 8-bit data", rd_got, pat({LATCH, 8'h77}));
        move(8'h04, 1'b0, 1'b0, 1'b0, 8'h05, 8'h66, 16'h0000, 8'h00);
        check("split 8-bit on chip", {saw_on, on_addr}, 16'h0566 | 17'h10000);
    endtask : s_split

    task automatic s_bank();
        move(8'h08, 1'b0, 1'b1, 1'b0, 8'h41, 8'h12, 16'h0000, 8'hC3);
        check("bank 8-bit addr", ex_addr, 16'h4112);
        check("bank 8-bit oe", {nmux, hi, lo}, 16'h0003);
        move(8'h18, 1'b0, 1'b0, 1'b0, 8'h41, 8'h12, 16'h0000, 8'h00);
        check("nonmux bank select", {nmux, hi, lo}, 16'h0007);
        check("nonmux read back", rd_got, 16'h00C3);
    endtask : s_bank

    task automatic s_external();
        move(8'h0C, 1'b0, 1'b0, 1'b0, 8'h7E, 8'h10, 16'h0000, 8'h00);
        check("external low addr off", saw_on, 16'h0000);
        check("external 8-bit addr", ex_addr, 16'h0010);
        check("external 8-bit oe", {hi, lo}, 16'h0001);
        check("external 8-bit data", rd_got, pat({LATCH, 8'h10}));
        move(8'h0C, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00, 16'h0020, 8'h00);
        check("external 16-bit off", saw_on, 16'h0000);
        check("external 16-bit addr", ex_addr, 16'h0020);
        check("external hold", {stable, hi, lo, 16'(n_strb)}, 16'(STROBE) | 19'h70000);
        check("external 16-bit data", rd_got, pat(16'h0020));
    endtask : s_external

    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        wrap_up();
    end

    initial begin
        error_cnt = 0;
        n_compared = 0;
        for (int i = 0; i < 8192; i++) ram[i] = 8'h00;
        {reset_i, move_req_i, move_wide_i, move_write_i, move_sel_one_i} <= 5'b10000;
        {move_wdata_i, memory_interface_config_i, external_data_ram_page_select_i} <= 24'h000000;
        {indirect_register_zero_i, indirect_register_one_i, data_pointer_i} <= 32'h00000000;
        repeat (10) @(posedge clk_sys_i);
        check("reset outputs", {busy_o, done_o, ext_rd_n_o, ext_wr_n_o}, 16'h0003);
        reset_i <= 1'b0;
        @(posedge clk_sys_i);
        s_internal();
        s_split();
        s_bank();
        s_external();
        wrap_up();
    end
endmodule : external_data_memory_address_mapper_tb
